// File: ard_chan.sv
`timescale 1ns/10ps
module ard_chan (
   // Clock and reset.
   input  wire logic                      ref_clk,
   input  wire logic                      arst_n,
   // Control from the register file.
   input  wire logic                      load_set,
   input  wire logic                      chan_rst,
   input  wire logic                      wrap,
   input  wire logic [ard_pkg::ADR_W-1:0] beg,
   input  wire logic [ard_pkg::CNT_W-1:0] size,
   // Converter side.
   input  wire logic [ard_pkg::DATA_W-1:0] result,
   input  wire logic                      ready,
   input  wire logic                      sat,
   // State and buffer write.
   output logic                           active_q,
   output logic                           ovf_q,
   output logic                           load_q,
   output logic [ard_pkg::ADR_W-1:0]      cur_q,
   output logic [ard_pkg::CNT_W-1:0]      cnt_q,
   output logic                           ram_wr_q,
   output logic [31:0]                    ram_addr_q,
   output logic [ard_pkg::DATA_W-1:0]     ram_data_q,
   output logic [ard_pkg::EVT_W-1:0]      evt_q
);
   import ard_pkg::*;

   ard_state_type    state_q;
   logic             start;
   logic             take;
   logic [CNT_W-1:0] cnt_inc;
   logic             hit_full;
   logic             hit_half;

   // Start, accept and buffer level decode.
   assign start    = load_q & (state_q == ARD_IDLE);
   assign take     = ready & (state_q == ARD_RUN);
   assign cnt_inc  = CNT_W'(cnt_q + 1'b1);
   assign hit_full = cnt_inc == size;
   assign hit_half = (size[CNT_W-1:1] != '0)
                   && (cnt_inc == {1'b0, size[CNT_W-1:1]});
   assign active_q = state_q == ARD_RUN;

   // Channel sequencing.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ARD_IDLE;
         load_q  <= 1'b0;
         ovf_q   <= 1'b0;
         cur_q   <= ADR_RST;
         cnt_q   <= CNT_RST;
      end else if (chan_rst) begin
         state_q <= ARD_IDLE;
         load_q  <= 1'b0;
         ovf_q   <= 1'b0;
         cur_q   <= beg;
         cnt_q   <= CNT_RST;
      end else begin
         if (start) begin
            state_q <= ARD_RUN;
            load_q  <= 1'b0;
            cur_q   <= beg;
            cnt_q   <= CNT_RST;
         end else begin
            if (load_set) begin
               load_q <= 1'b1;
            end
            if (take) begin
               cur_q <= (hit_full && wrap) ? beg
                        : ADR_W'(cur_q + 2'd2);
               cnt_q <= (hit_full && wrap) ? CNT_RST : cnt_inc;
               if (hit_full && !wrap) begin
                  state_q <= ARD_IDLE;
               end
            end
         end
         if (ready && !active_q) begin
            ovf_q <= 1'b1;
         end
      end
   end

   // Buffer write port and event pulses.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ram_wr_q   <= 1'b0;
         ram_addr_q <= RAM_BASE;
         ram_data_q <= '0;
         evt_q      <= EVT_RST;
      end else begin
         ram_wr_q   <= take;
         ram_addr_q <= RAM_BASE | {18'h00000, cur_q};
         if (take) begin
            ram_data_q <= result;
         end
         evt_q <= {ready & ~active_q, sat, take & hit_full,
                   take & hit_half, ready};
      end
   end

endmodule

// File: ard_evt.sv
`timescale 1ns/10ps
module ard_evt (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // Event manager side.
   ard_evt_if.mgr   ev
);
   import ard_pkg::*;

   logic [EVT_W-1:0] pend_q;
   logic [EVT_W-1:0] pend_d;
   logic [EVT_W-1:0] en_q;
   logic             irq_q;

   // Write one clears; a new event in the same cycle wins.
   assign pend_d = (pend_q & ~(ev.pend_wr ? ev.wdata : EVT_RST))
                 | ev.evt;

   // Flags, enables and the merged request.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_q <= EVT_RST;
         en_q   <= EVT_RST;
         irq_q  <= 1'b0;
      end else begin
         pend_q <= pend_d;
         if (ev.en_wr) begin
            en_q <= ev.wdata;
         end
         irq_q  <= |(pend_q & en_q);
      end
   end

   assign ev.pend = pend_q;
   assign ev.en   = en_q;
   assign ev.irq  = irq_q;

endmodule

// File: ard_evt_if.sv
`timescale 1ns/10ps
interface ard_evt_if;
   logic [4:0] evt;
   logic [4:0] wdata;
   logic       pend_wr;
   logic       en_wr;
   logic [4:0] pend;
   logic [4:0] en;
   logic       irq;

   modport ctl (output evt, output wdata, output pend_wr, output en_wr,
                input pend, input en, input irq);
   modport mgr (input evt, input wdata, input pend_wr, input en_wr,
                output pend, output en, output irq);
endinterface

// File: ard_pkg.sv
package ard_pkg;

   // Register byte addresses.
   localparam logic [31:0] ADDR_PEND = 32'h4000a810;
   localparam logic [31:0] ADDR_EN   = 32'h4000a850;
   localparam logic [31:0] ADDR_CTRL = 32'h4000d010;
   localparam logic [31:0] ADDR_STAT = 32'h4000d014;
   localparam logic [31:0] ADDR_BEG  = 32'h4000d018;
   localparam logic [31:0] ADDR_SIZE = 32'h4000d01c;
   localparam logic [31:0] ADDR_CUR  = 32'h4000d020;
   localparam logic [31:0] ADDR_CNT  = 32'h4000d024;

   // Fixed upper part of every buffer address, and its reset image.
   localparam logic [31:0] RAM_BASE  = 32'h2000_0000;

   // Field widths.
   localparam int unsigned ADR_W  = 14;
   localparam int unsigned CNT_W  = 13;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned EVT_W  = 5;

   // Event bit positions, shared by pending and enable registers.
   localparam int unsigned EVT_OVF  = 4;
   localparam int unsigned EVT_SAT  = 3;
   localparam int unsigned EVT_FULL = 2;
   localparam int unsigned EVT_HALF = 1;
   localparam int unsigned EVT_DATA = 0;

   // Control and status bit positions.
   localparam int unsigned CTRL_LOAD = 0;
   localparam int unsigned CTRL_WRAP = 1;
   localparam int unsigned CTRL_RST  = 4;
   localparam int unsigned STAT_ACT  = 0;
   localparam int unsigned STAT_OVF  = 1;

   // Reset values.
   localparam logic [EVT_W-1:0] EVT_RST  = 5'h00;
   localparam logic [ADR_W-1:0] ADR_RST  = 14'h0000;
   localparam logic [CNT_W-1:0] CNT_RST  = 13'h0000;

   typedef enum logic {ARD_IDLE, ARD_RUN} ard_state_type;

   // True when a bus address selects the given register.
   function automatic logic ard_hit(input logic [31:0] a,
                                    input logic [31:0] r);
      return a == r;
   endfunction

endpackage

// File: ard_ram_model.sv
`timescale 1ns/10ps
// Far-side model: buffer RAM and the top-level peripheral interrupt gate.
module ard_ram_model (
   // Clock.
   input  wire logic        ref_clk,
   // Buffer write port from the channel.
   input  wire logic        ram_wr_q,
   input  wire logic [31:0] ram_addr_q,
   input  wire logic [15:0] ram_data_q,
   // Merged request and the top-level peripheral enable.
   input  wire logic        periph_irq_q,
   input  wire logic        irq_gate,
   output logic             irq_taken
);
   logic [15:0] mem [logic [31:0]];

   // Each result word lands at its byte address.
   always @(posedge ref_clk) begin
      if (ram_wr_q === 1'b1) begin
         mem[ram_addr_q] = ram_data_q;
      end
   end

   // The top level only switches the whole peripheral on or off.
   assign irq_taken = periph_irq_q & irq_gate;
endmodule

// File: ard_tb_top.sv
`timescale 1ns/10ps
module ard_tb_top;
   import ard_pkg::*;
   logic        ref_clk;
   logic        arst_n;
   logic [31:0] reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata_q;
   logic [15:0] conv_result;
   logic        conv_result_ready;
   logic        gain_saturated;
   logic        ram_wr_q;
   logic [31:0] ram_addr_q;
   logic [15:0] ram_data_q;
   logic        periph_irq_q;
   logic        irq_taken;
   logic [31:0] exp_rd [$];
   logic [47:0] exp_wr [$];
   logic [31:0] nxt;
   logic        rd_d;
   int          err_total;
   int          comparisons;
   int          k;

   ard_top u_ard_top (
      .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .conv_result(conv_result),
      .conv_result_ready(conv_result_ready),
      .gain_saturated(gain_saturated), .ram_wr_q(ram_wr_q),
      .ram_addr_q(ram_addr_q), .ram_data_q(ram_data_q),
      .periph_irq_q(periph_irq_q));

   ard_ram_model u_ard_ram_model (
      .ref_clk(ref_clk), .ram_wr_q(ram_wr_q), .ram_addr_q(ram_addr_q),
      .ram_data_q(ram_data_q), .periph_irq_q(periph_irq_q),
      .irq_gate(1'b1), .irq_taken(irq_taken));

   // Free-running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input string nm, input logic [47:0] e,
                      input logic [47:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One-cycle register write.
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read; the expected word is queued.
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_rd.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   // Back-to-back results; stored ones queue their buffer write.
   task automatic put(input int n, input bit live);
      logic [15:0] d;
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         d = 16'($urandom);
         conv_result <= d;
         conv_result_ready <= 1'b1;
         if (live) exp_wr.push_back({nxt, d});
         nxt = (nxt == 32'h2000_0106) ? 32'h2000_0100 : nxt + 32'h2;
      end
      @(posedge ref_clk);
      conv_result_ready <= 1'b0;
   endtask

   // Single saturation pulse followed by settling time.
   task automatic sat();
      @(posedge ref_clk);
      gain_saturated <= 1'b1;
      @(posedge ref_clk);
      gain_saturated <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask

   // Watcher: takes the oldest note whenever a result shows.
   always @(posedge ref_clk) begin
      if (rd_d === 1'b1) begin
         if (exp_rd.size() == 0) chk("extra read", 48'h0, 48'h1);
         else chk("reg_rdata_q", {16'h0, exp_rd.pop_front()},
                  {16'h0, reg_rdata_q});
      end
      if (ram_wr_q === 1'b1) begin
         if (exp_wr.size() == 0) chk("extra ram write", 48'h0, 48'h1);
         else chk("ram write", exp_wr.pop_front(), {ram_addr_q, ram_data_q});
      end
      rd_d <= reg_rd;
   end

   // Hang guard.
   initial begin
      repeat (20000) @(posedge ref_clk);
      chk("timeout", 48'h0, 48'h1);
      finish_test();
   end

   // Main sequence.
   initial begin
      arst_n = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      conv_result = 16'h0;
      conv_result_ready = 1'b0;
      gain_saturated = 1'b0;
      rd_d = 1'b0;
      nxt = 32'h2000_0100;
      void'($urandom(96597));
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(ADDR_PEND, 32'h0);
      rd(ADDR_EN, 32'h0);
      rd(ADDR_CUR, 32'h2000_0000);
      rd(ADDR_CNT, 32'h0);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_STAT, 32'h0);
      rd(ADDR_BEG, 32'h2000_0000);
      rd(ADDR_SIZE, 32'h0);
      rd(32'h4000_d028, 32'h0);
      wr(ADDR_CUR, 32'hffff_ffff);
      wr(ADDR_CNT, 32'hffff_ffff);
      rd(ADDR_CUR, 32'h2000_0000);
      rd(ADDR_CNT, 32'h0);
      $display("test reset_values done");
      wr(ADDR_EN, 32'h1f);
      rd(ADDR_EN, 32'h1f);
      wr(ADDR_BEG, 32'h100);
      wr(ADDR_SIZE, 32'h4);
      wr(ADDR_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      put(4, 1'b1);
      repeat (5) @(posedge ref_clk);
      rd(ADDR_CNT, 32'h4);
      rd(ADDR_CUR, 32'h2000_0108);
      rd(ADDR_STAT, 32'h0);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_PEND, 32'h07);
      chk("periph_irq_q", 48'h1, {47'h0, periph_irq_q});
      $display("test linear_fill done");
      put(1, 1'b0);
      repeat (4) @(posedge ref_clk);
      rd(ADDR_STAT, 32'h2);
      rd(ADDR_PEND, 32'h17);
      sat();
      rd(ADDR_PEND, 32'h1f);
      wr(ADDR_PEND, 32'h1f);
      repeat (4) @(posedge ref_clk);
      chk("periph_irq_q", 48'h0, {47'h0, periph_irq_q});
      rd(ADDR_PEND, 32'h0);
      rd(ADDR_STAT, 32'h2);
      $display("test overflow_clear done");
      wr(ADDR_EN, 32'h0);
      sat();
      chk("periph_irq_q", 48'h0, {47'h0, periph_irq_q});
      rd(ADDR_PEND, 32'h08);
      wr(ADDR_EN, 32'h08);
      repeat (4) @(posedge ref_clk);
      chk("periph_irq_q", 48'h1, {47'h0, periph_irq_q});
      chk("irq_taken", 48'h1, {47'h0, irq_taken});
      wr(ADDR_PEND, 32'h08);
      $display("test enable_mask done");
      wr(ADDR_CTRL, 32'h10);
      repeat (3) @(posedge ref_clk);
      rd(ADDR_STAT, 32'h0);
      rd(ADDR_CNT, 32'h0);
      rd(ADDR_CUR, 32'h2000_0100);
      rd(ADDR_CTRL, 32'h0);
      $display("test channel_reset done");
      nxt = 32'h2000_0100;
      wr(ADDR_CTRL, 32'h3);
      repeat (3) @(posedge ref_clk);
      put(5, 1'b1);
      repeat (5) @(posedge ref_clk);
      rd(ADDR_CNT, 32'h1);
      rd(ADDR_CUR, 32'h2000_0102);
      rd(ADDR_STAT, 32'h1);
      rd(ADDR_CTRL, 32'h2);
      $display("test wrap_mode done");
      for (k = 0; k < 20 && exp_rd.size() + exp_wr.size() > 0; k++) begin
         @(posedge ref_clk);
      end
      if (exp_rd.size() + exp_wr.size() > 0) chk("drain", 48'h0, 48'h1);
      finish_test();
   end
endmodule

// File: ard_top.sv
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module ard_top (
   // Clock and reset.
   input  wire logic                ref_clk,
   input  wire logic                arst_n,
   // Register port.
   input  wire logic [31:0]         reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata_q,
   // Converter results.
   input  wire logic [ard_pkg::DATA_W-1:0] conv_result,
   input  wire logic                conv_result_ready,
   input  wire logic                gain_saturated,
   // Buffer RAM write port.
   output logic                     ram_wr_q,
   output logic [31:0]              ram_addr_q,
   output logic [ard_pkg::DATA_W-1:0] ram_data_q,
   // Peripheral interrupt to the processor.
   output logic                     periph_irq_q
);
   import ard_pkg::*;

   ard_evt_if ev ();

   logic              wrap_q;
   logic [ADR_W-1:0]  beg_q;
   logic [CNT_W-1:0]  size_q;
   logic              active_q;
   logic              ovf_q;
   logic              load_q;
   logic [ADR_W-1:0]  cur_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [EVT_W-1:0]  evt_q;
   logic              wr_ctrl;
   logic              wr_beg;
   logic              wr_size;
   logic              load_set;
   logic              chan_rst;
   logic [31:0]       rd_mux;

   // Write decode for the control registers.
   assign wr_ctrl   = reg_wr & ard_hit(reg_addr, ADDR_CTRL);
   assign wr_beg    = reg_wr & ard_hit(reg_addr, ADDR_BEG);
   assign wr_size   = reg_wr & ard_hit(reg_addr, ADDR_SIZE);
   assign load_set  = wr_ctrl & reg_wdata[CTRL_LOAD];
   assign chan_rst  = wr_ctrl & reg_wdata[CTRL_RST];

   // Event manager connection.
   assign ev.evt     = evt_q;
   assign ev.wdata   = reg_wdata[EVT_W-1:0];
   assign ev.pend_wr = reg_wr & ard_hit(reg_addr, ADDR_PEND);
   assign ev.en_wr   = reg_wr & ard_hit(reg_addr, ADDR_EN);
   assign periph_irq_q = ev.irq;

   // Read selection; unmapped addresses read as zero.
   assign rd_mux =
        ard_hit(reg_addr, ADDR_PEND) ? {27'h0000000, ev.pend}
      : ard_hit(reg_addr, ADDR_EN)   ? {27'h0000000, ev.en}
      : ard_hit(reg_addr, ADDR_CTRL) ? {30'h00000000, wrap_q, load_q}
      : ard_hit(reg_addr, ADDR_STAT) ? {30'h00000000, ovf_q, active_q}
      : ard_hit(reg_addr, ADDR_BEG)  ? RAM_BASE | {18'h00000, beg_q}
      : ard_hit(reg_addr, ADDR_SIZE) ? {19'h00000, size_q}
      : ard_hit(reg_addr, ADDR_CUR)  ? RAM_BASE | {18'h00000, cur_q}
      : ard_hit(reg_addr, ADDR_CNT)  ? {19'h00000, cnt_q}
      : 32'h00000000;

   // Configuration registers and read data, valid one cycle only.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrap_q      <= 1'b0;
         beg_q       <= ADR_RST;
         size_q      <= CNT_RST;
         reg_rdata_q <= 32'h00000000;
      end else begin
         if (wr_ctrl) begin
            wrap_q <= reg_wdata[CTRL_WRAP];
         end
         if (wr_beg) begin
            beg_q <= {reg_wdata[ADR_W-1:1], 1'b0};
         end
         if (wr_size) begin
            size_q <= reg_wdata[CNT_W-1:0];
         end
         reg_rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // Channel address, count and event generation.
   ard_chan u_chan (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .load_set   (load_set),
      .chan_rst   (chan_rst),
      .wrap       (wrap_q),
      .beg        (beg_q),
      .size       (size_q),
      .result     (conv_result),
      .ready      (conv_result_ready),
      .sat        (gain_saturated),
      .active_q   (active_q),
      .ovf_q      (ovf_q),
      .load_q     (load_q),
      .cur_q      (cur_q),
      .cnt_q      (cnt_q),
      .ram_wr_q   (ram_wr_q),
      .ram_addr_q (ram_addr_q),
      .ram_data_q (ram_data_q),
      .evt_q      (evt_q)
   );

   // Pending flags, enables and merged request.
   ard_evt u_evt (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .ev      (ev)
   );

   // Checks on the block's own behaviour.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_rd_cnt;
      reg_rd && ard_hit(reg_addr, ADDR_CNT);
   endsequence

   sequence s_rd_cur;
      reg_rd && ard_hit(reg_addr, ADDR_CUR);
   endsequence

   sequence s_load_idle;
      load_set && !chan_rst && !active_q && !load_q;
   endsequence

   sequence s_started;
      active_q && !load_q;
   endsequence

   sequence s_rst_wr;
      chan_rst;
   endsequence

   property p_cur_read;
      s_rd_cur |=> reg_rdata_q[31:ADR_W] == RAM_BASE[31:ADR_W]
                   && !reg_rdata_q[0]
                   && reg_rdata_q[ADR_W-1:1] == $past(cur_q[ADR_W-1:1]);
   endproperty
   a_cur_read: assert property (p_cur_read)
      else $error("next address read wrong");

   property p_cnt_read;
      s_rd_cnt |=> reg_rdata_q == {19'h00000, $past(cnt_q)};
   endproperty
   a_cnt_read: assert property (p_cnt_read)
      else $error("count read wrong");

   property p_ovf_evt;
      conv_result_ready && !active_q |-> ##2 ev.pend[EVT_OVF];
   endproperty
   a_ovf_evt: assert property (p_ovf_evt)
      else $error("overflow flag not set");

   property p_sat_evt;
      gain_saturated |-> ##2 ev.pend[EVT_SAT];
   endproperty
   a_sat_evt: assert property (p_sat_evt)
      else $error("saturation flag not set");

   property p_full_evt;
      ram_wr_q && !wrap_q && cnt_q == size_q |-> ##1 ev.pend[EVT_FULL];
   endproperty
   a_full_evt: assert property (p_full_evt)
      else $error("full flag not set");

   property p_half_evt;
      ram_wr_q && size_q[CNT_W-1:1] != '0
      && cnt_q == {1'b0, size_q[CNT_W-1:1]} |-> ##1 ev.pend[EVT_HALF];
   endproperty
   a_half_evt: assert property (p_half_evt)
      else $error("half flag not set");

   property p_data_evt;
      conv_result_ready |-> ##2 ev.pend[EVT_DATA];
   endproperty
   a_data_evt: assert property (p_data_evt)
      else $error("data flag not set");

   property p_en_write;
      ev.en_wr |=> ev.en == $past(reg_wdata[EVT_W-1:0]);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable write lost");

   property p_irq_src;
      periph_irq_q |-> $past(|(ev.pend & ev.en));
   endproperty
   a_irq_src: assert property (p_irq_src)
      else $error("interrupt without enabled source");

   property p_load;
      s_load_idle |-> ##2 s_started;
   endproperty
   a_load: assert property (p_load)
      else $error("load did not start channel");

   property p_linear_stop;
      ram_wr_q && !wrap_q && cnt_q == size_q |-> !active_q;
   endproperty
   a_linear_stop: assert property (p_linear_stop)
      else $error("linear channel kept running");

   property p_ovf_sticky;
      ovf_q && !chan_rst |=> ovf_q;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky)
      else $error("overflow status dropped");

   property p_chan_rst;
      s_rst_wr |=> !active_q && !ovf_q && !load_q && cnt_q == '0;
   endproperty
   a_chan_rst: assert property (p_chan_rst)
      else $error("channel reset incomplete");

   property p_irq_hold;
      (|(ev.pend & ev.en)) |=> periph_irq_q;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("request not raised");

endmodule
